/* File: verilog/region_remap_pkg.sv */
// Purpose: Shared constants and types for the region remap and stall resume block.
// Assumes: A 32-bit APB register window with byte addresses in the low eight bits.
// Notes: Every offset, bit position, mask and encoding used by the design lives here.
`default_nettype none

package region_remap_pkg;

	// ==========================================================================
	// Register map
	// ==========================================================================
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_REMAP = 8'h00;
	localparam logic [7:0] OFF_RESUME = 8'h04;
	localparam logic [7:0] OFF_TABLE_CTRL = 8'h08;
	localparam logic [7:0] OFF_ATTR_IND = 8'h0C;
	localparam logic [7:0] OFF_FAULT_STATUS = 8'h10;
	localparam logic [7:0] OFF_FAULT_MODEL = 8'h14;

	// ==========================================================================
	// Field positions
	// ==========================================================================
	localparam int EXT_ADDR_EN_BIT = 31;
	localparam int STALLED_BIT = 30;
	localparam int STALL_MODEL_BIT = 0;
	localparam int TERMINATE_NOT_RETRY_BIT = 0;
	localparam int OUTER_MAP_LSB = 24;
	localparam int NORMAL_SHARED_ONE_BIT = 19;
	localparam int NORMAL_SHARED_ZERO_BIT = 18;
	localparam int DEVICE_SHARED_ONE_BIT = 17;
	localparam int DEVICE_SHARED_ZERO_BIT = 16;
	localparam int TYPE_FIELD_W = 2;
	localparam int ATTR_BYTE_W = 8;

	// ==========================================================================
	// Masks and reset values
	// ==========================================================================
	// Bits 23:20 are reserved and always read as zero.
	localparam logic [31:0] REMAP_MASK_OUTER = 32'hFF0F_FFFF;
	localparam logic [31:0] REMAP_MASK_NO_OUTER = 32'h000F_FFFF;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// The remap word has no defined reset value; zero is chosen for a clean start.
	localparam logic [31:0] REMAP_RESET = 32'h0000_0000;
	localparam logic [31:0] TABLE_CTRL_MASK = 32'h8000_0000;
	localparam logic [31:0] FAULT_MODEL_MASK = 32'h0000_0001;

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef enum logic [1:0] {
		MT_STRONG = 2'h0,
		MT_DEVICE = 2'h1,
		MT_NORMAL = 2'h2,
		MT_RESERVED = 2'h3
	} mem_type_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_STALLED = 2'h1
	} stall_state_t;

endpackage

`default_nettype wire

/* File: verilog/remap_attr_decode.sv */
// Purpose: Combinational short-descriptor attribute remap from the primary remap word.
// Assumes: The remap word already has reserved bits forced to zero.
// Notes: Index 6 uses the standard decode; no custom meaning is implemented.
`timescale 1ns/10ps
`default_nettype none

module remap_attr_decode (
	// Remap word
	input wire logic [31:0] remap_word,
	// Entry attribute bits
	input wire logic tex0,
	input wire logic cacheable,
	input wire logic bufferable,
	input wire logic share_bit,
	// Decoded attributes
	output region_remap_pkg::mem_type_t mem_type,
	output logic shareable,
	output logic outer_shareable
);

	logic [2:0] idx;
	logic [1:0] field;

	// ==========================================================================
	// Index and field select
	// ==========================================================================
	// index and field
	assign idx = {tex0, cacheable, bufferable};
	assign field = remap_word[{idx, 1'b0} +: region_remap_pkg::TYPE_FIELD_W];

	// type decode, index six standard
	// The reserved code maps to strongly ordered, the safest of the choices.
	always_comb begin
		case (field)
			2'h0: mem_type = region_remap_pkg::MT_STRONG;
			2'h1: mem_type = region_remap_pkg::MT_DEVICE;
			2'h2: mem_type = region_remap_pkg::MT_NORMAL;
			default: mem_type = region_remap_pkg::MT_STRONG;
		endcase
	end

	// ==========================================================================
	// Shareability
	// ==========================================================================
	// shared mapping bits
	// Strongly ordered memory is always shareable.
	always_comb begin
		case (mem_type)
			region_remap_pkg::MT_NORMAL: begin
				shareable = share_bit ? remap_word[region_remap_pkg::NORMAL_SHARED_ONE_BIT]
					: remap_word[region_remap_pkg::NORMAL_SHARED_ZERO_BIT];
			end
			region_remap_pkg::MT_DEVICE: begin
				shareable = share_bit ? remap_word[region_remap_pkg::DEVICE_SHARED_ONE_BIT]
					: remap_word[region_remap_pkg::DEVICE_SHARED_ZERO_BIT];
			end
			default: shareable = 1'b1;
		endcase
	end

	// outer map bit, zero selects outer
	assign outer_shareable = (mem_type == region_remap_pkg::MT_NORMAL) && shareable
		&& !remap_word[region_remap_pkg::OUTER_MAP_LSB + idx];

endmodule

`default_nettype wire

/* File: verilog/region_remap_and_stall_resume.sv */
// Purpose: Context bank remap lookup and stalled transaction resume control behind APB.
// Assumes: Lookup and stall requests come from logic on pclk; APB answers in one access cycle.
// Notes: Lookup results appear one cycle after the request, from registered outputs.
//
// Behaviour
// - Remap word serves only while extended address enable is zero; else attribute register.
// - Remap word is a 32-bit read-write register, programmed by software before use.
// - Index is type-extension bit, cacheable, bufferable; selects field at bits 2k+1:2k.
// - Field 00 strongly ordered, 01 device, 10 normal, 11 reserved.
// - Bits 31:24 per index: zero gives outer shareable for shareable normal memory.
// - Without inner/outer distinction, outer map bits read zero and ignore writes.
// - Index six may carry a custom meaning; here it decodes like the rest.
// - Normal memory with entry share bit one takes shareability from bit 19.
// - Normal memory with entry share bit zero takes shareability from bit 18.
// - Device memory with entry share bit one takes shareability from bit 17.
// - Device memory with entry share bit zero takes shareability from bit 16.
// - Resume control is write only; bit 0 zero retries, one terminates the stall.
// - Only a resume control write clears the stalled flag.
// - Retry re-runs before table control is used, so its changes take effect.
// - A nested translation stalled in stage two restarts from stage one.
// - A retry may restart earlier, such as repeating security state determination.
`timescale 1ns/10ps
`default_nettype none

module region_remap_and_stall_resume #(
	parameter bit OUTER_DISTINCT = 1'b1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Lookup request
	input wire logic lk_valid,
	input wire logic [31:0] lk_addr,
	input wire logic lk_tex0,
	input wire logic lk_c,
	input wire logic lk_b,
	input wire logic lk_s,
	// Lookup answer
	output logic rsp_valid,
	output logic [31:0] rsp_addr,
	output logic [1:0] rsp_mem_type,
	output logic rsp_shareable,
	output logic rsp_outer_shareable,
	output logic rsp_long_desc,
	output logic [7:0] rsp_attr,
	// Stall path
	input wire logic stall_req,
	input wire logic stall_stage_two,
	output logic stalled,
	output logic retry_pulse,
	output logic retry_from_stage_one,
	output logic terminate_pulse
);

	// ==========================================================================
	// Helpers
	// ==========================================================================
	// Address match on the word offset, used by reads and writes alike.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		mapped = hit(addr, region_remap_pkg::OFF_REMAP) || hit(addr, region_remap_pkg::OFF_RESUME)
			|| hit(addr, region_remap_pkg::OFF_TABLE_CTRL) || hit(addr, region_remap_pkg::OFF_ATTR_IND)
			|| hit(addr, region_remap_pkg::OFF_FAULT_STATUS)
			|| hit(addr, region_remap_pkg::OFF_FAULT_MODEL);
	endfunction

	localparam logic [31:0] REMAP_MASK = OUTER_DISTINCT ? region_remap_pkg::REMAP_MASK_OUTER
		: region_remap_pkg::REMAP_MASK_NO_OUTER;

	logic [31:0] remap_ff;
	logic [31:0] table_ctrl_ff;
	logic [31:0] attr_ind_ff;
	logic [31:0] fault_model_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] nxt_prdata;
	logic setup;
	logic wr;
	logic resume_wr;
	logic ext_addr_en;
	logic stall_model;
	region_remap_pkg::stall_state_t state_ff;
	region_remap_pkg::stall_state_t nxt_state;
	logic stage_two_ff;
	logic retry_ff;
	logic retry_s1_ff;
	logic term_ff;
	region_remap_pkg::mem_type_t dec_type;
	logic dec_share;
	logic dec_outer;
	logic rsp_valid_ff;
	logic [31:0] rsp_addr_ff;
	logic [1:0] rsp_type_ff;
	logic rsp_share_ff;
	logic rsp_outer_ff;
	logic rsp_long_ff;
	logic [7:0] rsp_attr_ff;

	// ==========================================================================
	// APB slave
	// ==========================================================================
	// The read word is captured in the setup cycle so the access cycle answers at once.
	assign setup = psel && !penable;
	assign wr = psel && penable && pready_ff && pwrite;
	assign resume_wr = wr && hit(paddr, region_remap_pkg::OFF_RESUME);
	assign ext_addr_en = table_ctrl_ff[region_remap_pkg::EXT_ADDR_EN_BIT];
	assign stall_model = fault_model_ff[region_remap_pkg::STALL_MODEL_BIT];

	// Read multiplexer; resume control is write only and reads as zero.
	always_comb begin
		nxt_prdata = region_remap_pkg::WORD_ZERO;
		case (paddr)
			region_remap_pkg::OFF_REMAP: nxt_prdata = remap_ff;
			region_remap_pkg::OFF_TABLE_CTRL: nxt_prdata = table_ctrl_ff;
			region_remap_pkg::OFF_ATTR_IND: nxt_prdata = attr_ind_ff;
			region_remap_pkg::OFF_FAULT_STATUS: begin
				nxt_prdata[region_remap_pkg::STALLED_BIT] = (state_ff == region_remap_pkg::ST_STALLED);
			end
			region_remap_pkg::OFF_FAULT_MODEL: nxt_prdata = fault_model_ff;
			default: nxt_prdata = region_remap_pkg::WORD_ZERO;
		endcase
	end

	// Handshake flops: one-cycle access, error on an unmapped address.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= region_remap_pkg::WORD_ZERO;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup && !mapped(paddr);
			if (setup && !pwrite) begin
				prdata_ff <= nxt_prdata;
			end
		end
	end

	// remap register write, reserved bits dropped, outer bits too when OUTER_DISTINCT is zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remap_ff <= region_remap_pkg::REMAP_RESET;
		end else if (wr && hit(paddr, region_remap_pkg::OFF_REMAP)) begin
			remap_ff <= pwdata & REMAP_MASK;
		end
	end

	// Control words steering the lookup selection and fault model.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			table_ctrl_ff <= region_remap_pkg::WORD_ZERO;
			attr_ind_ff <= region_remap_pkg::WORD_ZERO;
			fault_model_ff <= region_remap_pkg::WORD_ZERO;
		end else begin
			if (wr && hit(paddr, region_remap_pkg::OFF_TABLE_CTRL)) begin
				table_ctrl_ff <= pwdata & region_remap_pkg::TABLE_CTRL_MASK;
			end
			if (wr && hit(paddr, region_remap_pkg::OFF_ATTR_IND)) begin
				attr_ind_ff <= pwdata;
			end
			if (wr && hit(paddr, region_remap_pkg::OFF_FAULT_MODEL)) begin
				fault_model_ff <= pwdata & region_remap_pkg::FAULT_MODEL_MASK;
			end
		end
	end

	// ==========================================================================
	// Attribute lookup
	// ==========================================================================
	remap_attr_decode u_decode (
		.remap_word(remap_ff),
		.tex0(lk_tex0),
		.cacheable(lk_c),
		.bufferable(lk_b),
		.share_bit(lk_s),
		.mem_type(dec_type),
		.shareable(dec_share),
		.outer_shareable(dec_outer)
	);

	// registered answer, format select
	// Registers are read in the lookup cycle itself, so a write one cycle earlier counts.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_valid_ff <= 1'b0;
			rsp_addr_ff <= region_remap_pkg::WORD_ZERO;
			rsp_type_ff <= region_remap_pkg::MT_STRONG;
			rsp_share_ff <= 1'b0;
			rsp_outer_ff <= 1'b0;
			rsp_long_ff <= 1'b0;
			rsp_attr_ff <= 8'h00;
		end else begin
			rsp_valid_ff <= lk_valid;
			if (lk_valid) begin
				rsp_addr_ff <= lk_addr;
				rsp_long_ff <= ext_addr_en;
				if (ext_addr_en) begin
					rsp_type_ff <= region_remap_pkg::MT_STRONG;
					rsp_share_ff <= 1'b0;
					rsp_outer_ff <= 1'b0;
					rsp_attr_ff <= attr_ind_ff[{lk_c, lk_b, 3'h0} +: region_remap_pkg::ATTR_BYTE_W];
				end else begin
					rsp_type_ff <= dec_type;
					rsp_share_ff <= dec_share;
					rsp_outer_ff <= dec_outer;
					rsp_attr_ff <= 8'h00;
				end
			end
		end
	end

	// ==========================================================================
	// Stall and resume
	// ==========================================================================
	// only resume clears, new stall wins
	// model change while stalled is not guarded
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			region_remap_pkg::ST_RUN: begin
				if (stall_req && stall_model) begin
					nxt_state = region_remap_pkg::ST_STALLED;
				end
			end
			region_remap_pkg::ST_STALLED: begin
				if (resume_wr && !stall_req) begin
					nxt_state = region_remap_pkg::ST_RUN;
				end
			end
			default: nxt_state = region_remap_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= region_remap_pkg::ST_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Which stage stalled, kept only for the stage-two cover; the retry always names stage one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_two_ff <= 1'b0;
		end else if (stall_req && stall_model && (state_ff == region_remap_pkg::ST_RUN)) begin
			stage_two_ff <= stall_stage_two;
		end
	end

	// retry or terminate, restart at stage one
	// Every retry restarts at stage one, ahead of table control use; that also covers
	// the earlier restart allowance. A terminate-model stall ends at once.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retry_ff <= 1'b0;
			retry_s1_ff <= 1'b0;
			term_ff <= 1'b0;
		end else begin
			retry_ff <= (state_ff == region_remap_pkg::ST_STALLED) && resume_wr
				&& !pwdata[region_remap_pkg::TERMINATE_NOT_RETRY_BIT];
			retry_s1_ff <= (state_ff == region_remap_pkg::ST_STALLED) && resume_wr
				&& !pwdata[region_remap_pkg::TERMINATE_NOT_RETRY_BIT];
			term_ff <= ((state_ff == region_remap_pkg::ST_STALLED) && resume_wr
				&& pwdata[region_remap_pkg::TERMINATE_NOT_RETRY_BIT])
				|| ((state_ff == region_remap_pkg::ST_RUN) && stall_req && !stall_model);
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_addr = rsp_addr_ff;
	assign rsp_mem_type = rsp_type_ff;
	assign rsp_shareable = rsp_share_ff;
	assign rsp_outer_shareable = rsp_outer_ff;
	assign rsp_long_desc = rsp_long_ff;
	assign rsp_attr = rsp_attr_ff;
	assign stalled = (state_ff == region_remap_pkg::ST_STALLED);
	assign retry_pulse = retry_ff;
	assign retry_from_stage_one = retry_s1_ff;
	assign terminate_pulse = term_ff;

	// ==========================================================================
	// Assertions
	// ==========================================================================
	logic short_lk;
	logic [2:0] lk_idx;
	assign short_lk = lk_valid && !ext_addr_en;
	assign lk_idx = {lk_tex0, lk_c, lk_b};

	AST_LONG_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
		lk_valid && ext_addr_en |=> rsp_long_desc && rsp_attr == $past(attr_ind_ff[{lk_c, lk_b, 3'h0} +: 8]))
		else $error("Long format lookup did not use the attribute register.");

	AST_REMAP_STORE: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == region_remap_pkg::OFF_REMAP |=> remap_ff == $past(pwdata & REMAP_MASK))
		else $error("Remap write was not stored.");

	AST_TYPE_FIELD: assert property (@(posedge pclk) disable iff (!presetn)
		short_lk && remap_ff[{lk_idx, 1'b0} +: 2] != 2'h3 |=>
		rsp_mem_type == $past(remap_ff[{lk_idx, 1'b0} +: 2]))
		else $error("Memory type did not follow the indexed field.");

	AST_OUTER_MAP: assert property (@(posedge pclk) disable iff (!presetn)
		short_lk && dec_type == region_remap_pkg::MT_NORMAL && dec_share |=>
		rsp_outer_shareable == !$past(remap_ff[region_remap_pkg::OUTER_MAP_LSB + lk_idx]))
		else $error("Outer shareable did not follow its map bit.");

	AST_OUTER_RAZ: assert property (@(posedge pclk) disable iff (!presetn)
		(remap_ff & ~REMAP_MASK) == region_remap_pkg::WORD_ZERO)
		else $error("Reserved or absent remap bits are not zero.");

	AST_NORMAL_SHARE: assert property (@(posedge pclk) disable iff (!presetn)
		short_lk && dec_type == region_remap_pkg::MT_NORMAL |=>
		rsp_shareable == ($past(lk_s) ? $past(remap_ff[19]) : $past(remap_ff[18])))
		else $error("Normal memory shareability wrong.");

	AST_DEVICE_SHARE: assert property (@(posedge pclk) disable iff (!presetn)
		short_lk && dec_type == region_remap_pkg::MT_DEVICE |=>
		rsp_shareable == ($past(lk_s) ? $past(remap_ff[17]) : $past(remap_ff[16])))
		else $error("Device memory shareability wrong.");

	AST_RETRY: assert property (@(posedge pclk) disable iff (!presetn)
		stalled && resume_wr && !pwdata[0] |=> retry_pulse && retry_from_stage_one && !terminate_pulse)
		else $error("Retry write did not retry.");

	AST_TERMINATE: assert property (@(posedge pclk) disable iff (!presetn)
		stalled && resume_wr && pwdata[0] |=> terminate_pulse && !retry_pulse)
		else $error("Terminate write did not terminate.");

	AST_STALL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		stalled && !resume_wr |=> stalled)
		else $error("Stalled flag cleared without a resume write.");

	COV_STALL_RETRY: cover property (@(posedge pclk) disable iff (!presetn)
		stalled && resume_wr && !pwdata[0]);
	COV_STAGE_TWO: cover property (@(posedge pclk) disable iff (!presetn)
		stalled && stage_two_ff ##[1:50] retry_pulse);
	COV_OUTER: cover property (@(posedge pclk) disable iff (!presetn)
		rsp_valid && rsp_outer_shareable);

endmodule

`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the region remap and stall resume block.
// Assumes: APB answers with one access cycle; lookup and stall answers come one cycle later.
// Notes: Expected attributes are derived here from the remap word, never from the design.
`timescale 1ns/10ps
`default_nettype none

module tb;
	// Clock, reset and APB.
	logic pclk, presetn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr;
	// Lookup and stall paths.
	logic lk_valid, lk_tex0, lk_c, lk_b, lk_s, rsp_valid, rsp_shareable, rsp_outer_shareable;
	logic [31:0] lk_addr, rsp_addr;
	logic [1:0] rsp_mem_type;
	logic rsp_long_desc, stall_req, stall_stage_two, stalled;
	logic retry_pulse, retry_from_stage_one, terminate_pulse;
	logic [7:0] rsp_attr;
	logic [31:0] rdv, word;
	logic errv;
	int num_errors = 0;
	int samples_checked = 0;

	region_remap_and_stall_resume region_remap_and_stall_resume_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lk_valid(lk_valid), .lk_addr(lk_addr), .lk_tex0(lk_tex0), .lk_c(lk_c), .lk_b(lk_b),
		.lk_s(lk_s), .rsp_valid(rsp_valid), .rsp_addr(rsp_addr), .rsp_mem_type(rsp_mem_type),
		.rsp_shareable(rsp_shareable), .rsp_outer_shareable(rsp_outer_shareable),
		.rsp_long_desc(rsp_long_desc), .rsp_attr(rsp_attr), .stall_req(stall_req),
		.stall_stage_two(stall_stage_two), .stalled(stalled), .retry_pulse(retry_pulse),
		.retry_from_stage_one(retry_from_stage_one), .terminate_pulse(terminate_pulse));

	// ==========================================================================
	// Clock and watchdog
	// ==========================================================================
	// A 50 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// The tests need under two hundred cycles; a hang is cut off far beyond that.
	initial begin
		#400000;
		num_errors++;
		results();
	end

	// ==========================================================================
	// Tasks
	// ==========================================================================
	// Verdict and end of run.
	task automatic results();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Compare any result, widened to a word, with case equality.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; read data and error are taken at the edge where pready is seen.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so that the next call never drives psel twice in one step.
		@(posedge pclk);
	endtask

	// Short lookup with index k and share bit s; the answer is checked one cycle later.
	task automatic lookup(input int k, input logic s, input logic [31:0] exp_word);
		lk_valid <= 1'b1;
		{lk_tex0, lk_c, lk_b} <= 3'(k);
		lk_s <= s;
		lk_addr <= 32'h1000_0000 + 32'(k);
		@(posedge pclk);
		lk_valid <= 1'b0;
		@(posedge pclk);
		chk({10'h0, rsp_valid, rsp_addr[7:0], rsp_long_desc, rsp_mem_type, rsp_shareable,
			rsp_outer_shareable, rsp_attr}, exp_word);
		chk(rsp_addr, 32'h1000_0000 + 32'(k));
	endtask

	// Raise one stall event and check that the flag stands.
	task automatic stall_event();
		stall_req <= 1'b1;
		stall_stage_two <= 1'b1;
		@(posedge pclk);
		stall_req <= 1'b0;
		@(posedge pclk);
		chk(32'(stalled), 32'h0000_0001);
	endtask

	// Short-format result: type, share and outer share from the remap word.
	function automatic logic [31:0] expect_short(input logic [31:0] w, input int k, input logic s);
		logic [1:0] t;
		logic sh, os;
		t = w[2*k +: 2];
		if (t == 2'h3) t = 2'h0;
		sh = (t == 2'h0) ? 1'b1 : (t == 2'h1) ? (s ? w[17] : w[16]) : (s ? w[19] : w[18]);
		os = (t == 2'h2) && sh && !w[24+k];
		return {10'h0, 1'b1, 8'(k), 1'b0, t, sh, os, 8'h00};
	endfunction

	// ==========================================================================
	// Test sequence
	// ==========================================================================
	initial begin
		{presetn, psel, penable, pwrite, lk_valid, lk_tex0, lk_c, lk_b, lk_s} = '0;
		{stall_req, stall_stage_two} = '0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		lk_addr = 32'h0000_0000;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values, write-only read, unmapped access.
		apb(1'b0, region_remap_pkg::OFF_REMAP, 32'h0);
		chk(rdv, 32'h0000_0000);
		apb(1'b0, region_remap_pkg::OFF_RESUME, 32'h0);
		chk(rdv, 32'h0000_0000);
		apb(1'b1, 8'h40, 32'hFFFF_FFFF);
		chk(32'(errv), 32'h0000_0001);
		// Remap word readback with reserved bits, then every index and share bit.
		for (int i = 0; i < 2; i++) begin
			word = (i == 0) ? 32'hA5F9_A6E4 : 32'h5A06_1B93;
			apb(1'b1, region_remap_pkg::OFF_REMAP, word);
			apb(1'b0, region_remap_pkg::OFF_REMAP, 32'h0);
			chk(rdv, word & 32'hFF0F_FFFF);
			for (int k = 0; k < 8; k++) begin
				lookup(k, 1'b0, expect_short(word, k, 1'b0));
				lookup(k, 1'b1, expect_short(word, k, 1'b1));
			end
		end
		// Long format replaces the remap word.
		apb(1'b1, region_remap_pkg::OFF_TABLE_CTRL, 32'hFFFF_FFFF);
		apb(1'b1, region_remap_pkg::OFF_ATTR_IND, 32'h4433_2211);
		lookup(6, 1'b1, {10'h0, 1'b1, 8'h06, 1'b1, 4'h0, 8'h33});
		apb(1'b1, region_remap_pkg::OFF_TABLE_CTRL, 32'h0);
		// Terminate model: a stall event ends at once and leaves the flag clear.
		stall_req <= 1'b1;
		@(posedge pclk);
		stall_req <= 1'b0;
		@(posedge pclk);
		chk({28'h0, stalled, retry_pulse, retry_from_stage_one, terminate_pulse}, 32'h1);
		// Stall, failed clear through status, retry; the stall model stays selected.
		apb(1'b1, region_remap_pkg::OFF_FAULT_MODEL, 32'h0000_0001);
		stall_event();
		apb(1'b0, region_remap_pkg::OFF_FAULT_STATUS, 32'h0);
		chk(rdv, 32'h4000_0000);
		apb(1'b1, region_remap_pkg::OFF_FAULT_STATUS, 32'hFFFF_FFFF);
		@(posedge pclk);
		chk(32'(stalled), 32'h0000_0001);
		// The write returns at the edge after its access, where the pulse still stands.
		apb(1'b1, region_remap_pkg::OFF_RESUME, 32'hFFFF_FFFE);
		chk({28'h0, stalled, retry_pulse, retry_from_stage_one, terminate_pulse}, 32'h6);
		// Terminate, then a resume with nothing stalled.
		stall_event();
		apb(1'b1, region_remap_pkg::OFF_RESUME, 32'h0000_0001);
		chk({28'h0, stalled, retry_pulse, retry_from_stage_one, terminate_pulse}, 32'h1);
		apb(1'b1, region_remap_pkg::OFF_RESUME, 32'h0);
		chk({28'h0, stalled, retry_pulse, retry_from_stage_one, terminate_pulse}, 32'h0);
		results();
	end
endmodule

`default_nettype wire
